// [ssl_pkg.sv]
// Constants and field layout for the synthesizer serial load port
package ssl_pkg;

  // ==========================================================
  // Shift register and destination codes
  localparam int          SR_W         = 22;
  localparam int          CTL_W        = 2;
  localparam logic [1:0]  DEST_IF_REF  = 2'h0;
  localparam logic [1:0]  DEST_RF_REF  = 2'h1;
  localparam logic [1:0]  DEST_IF_N    = 2'h2;
  localparam logic [1:0]  DEST_RF_N    = 2'h3;
  localparam int          NUM_LATCH    = 4;
  localparam logic [21:0] LATCH_RST    = 22'h000000;

  // ==========================================================
  // Reference latch fields
  localparam int REF_LSB  = 2;
  localparam int REF_W    = 15;
  localparam int PSEL_BIT = 17;
  localparam int PWD_BIT  = 18;
  localparam int MON_LSB  = 19;
  localparam int MON_W    = 3;

  // ==========================================================
  // Counter latch fields, divide ratio is B * P + A
  localparam int A_LSB = 2;
  localparam int A_W   = 7;
  localparam int B_LSB = 9;
  localparam int B_W   = 13;
  localparam int DIV_W = 15;
  localparam int MOD_W = 8;

  // ==========================================================
  // Prescaler low moduli, the high one of each pair is one more
  localparam logic [7:0] RF_P_LO    = 8'h40;
  localparam logic [7:0] RF_P_HI    = 8'h80;
  localparam logic [7:0] RF_HB_P_LO = 8'h20;
  localparam logic [7:0] RF_HB_P_HI = 8'h40;
  localparam logic [7:0] IF_P_LO    = 8'h08;
  localparam logic [7:0] IF_P_HI    = 8'h10;
  localparam logic [7:0] REF_P      = 8'h01;

  // ==========================================================
  // Monitor output select codes
  localparam logic [2:0] MON_LOW    = 3'h0;
  localparam logic [2:0] MON_SR     = 3'h1;
  localparam logic [2:0] MON_RF_N   = 3'h2;
  localparam logic [2:0] MON_IF_N   = 3'h3;
  localparam logic [2:0] MON_RF_REF = 3'h4;
  localparam logic [2:0] MON_IF_REF = 3'h5;
  localparam logic [2:0] MON_LOCK   = 3'h6;
  localparam logic [2:0] MON_HIGH   = 3'h7;

  // ==========================================================
  // Lock window in clock cycles and pin synchroniser width
  localparam logic [3:0] LOCK_WIN = 4'h4;
  localparam int         NUM_PIN  = 6;

endpackage

// [ssl_dm_div.sv]
// Dual modulus divider: prescaler P or P+1 followed by swallow and main counters
`timescale 1ns/100ps
module ssl_dm_div (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        run,
  input  wire logic        step,
  input  wire logic [7:0]  p_val,
  input  wire logic [6:0]  a_val,
  input  wire logic [14:0] b_val,
  output logic             mod_ctl,
  output logic             term
);

  logic [7:0]  edge_r;
  logic [7:0]  edge_nxt;
  logic [14:0] cyc_r;
  logic [14:0] cyc_nxt;
  logic        term_r;
  logic        term_nxt;
  logic        swallow;
  logic [7:0]  modulus;

  // ==========================================================
  // Counting
  // Swallow phase divides by P+1 for the first A prescaler cycles
  always_comb begin
    swallow  = {8'h00, a_val} > cyc_r;
    modulus  = swallow ? p_val : p_val - 8'h01;
    edge_nxt = edge_r;
    cyc_nxt  = cyc_r;
    term_nxt = 1'b0;
    if (!run || b_val == 15'h0000) begin
      // Zero ratio or power save holds the chain idle
      edge_nxt = 8'h00;
      cyc_nxt  = 15'h0000;
    end else if (step) begin
      if (edge_r == modulus) begin
        edge_nxt = 8'h00;
        if (cyc_r == b_val - 15'h0001) begin
          cyc_nxt  = 15'h0000;
          term_nxt = 1'b1;
        end else begin
          cyc_nxt = cyc_r + 15'h0001;
        end
      end else begin
        edge_nxt = edge_r + 8'h01;
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_r  <= 8'h00;
      cyc_r   <= 15'h0000;
      term_r  <= 1'b0;
      mod_ctl <= 1'b0;
    end else if (clk_en) begin
      edge_r  <= edge_nxt;
      cyc_r   <= cyc_nxt;
      term_r  <= term_nxt;
      mod_ctl <= swallow & run;
    end
  end

  assign term = term_r;

endmodule

// [ssl_port.sv]
// Serial load port, latches, dividers and monitor output of a dual synthesizer
// Functional notes
// - Each rising serial clock edge shifts the data pin into a 22-bit shift register.
// - The word arrives most significant bit first, so the first bit ends at the top.
// - The last two bits shifted in are control bits naming the destination latch.
// - A rising load strobe copies the shift register into the latch the control bits name.
// - One digital output multiplexes counters, reference counters, lock and shift data.
// - RF prescaler runs 64/65 or 128/129, or 32/33 or 64/65 in the high band variant.
// - IF prescaler runs 8/9 or 16/17.
// - A serially programmed power save mode stops the synthesizer logic.
`timescale 1ns/100ps
module ssl_port #(
  parameter bit HIGH_BAND = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic ser_clk,
  input  wire logic ser_data,
  input  wire logic load_strobe,
  input  wire logic rf_prescaler_input,
  input  wire logic if_prescaler_input,
  input  wire logic reference_counter_input,
  output logic      muxed_monitor_output,
  output logic      rf_mod_ctl,
  output logic      if_mod_ctl,
  output logic      rf_power_down,
  output logic      if_power_down
);

  // ==========================================================
  // Pin synchronisers and edge history
  // Bit order: ser_clk, ser_data, load_strobe, rf, if, ref
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  logic [5:0] hist_r;
  logic [5:0] rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 6'h00;
      sync_r <= 6'h00;
      hist_r <= 6'h00;
    end else if (clk_en) begin
      meta_r <= {ser_clk, ser_data, load_strobe,
                 rf_prescaler_input, if_prescaler_input, reference_counter_input};
      sync_r <= meta_r;
      hist_r <= sync_r;
    end
  end

  // Edges only from the second and third stages
  assign rise = sync_r & ~hist_r;

  // ==========================================================
  // Shift register and latches
  logic [21:0] sr_r;
  logic [21:0] sr_nxt;
  logic [21:0] latch_r   [ssl_pkg::NUM_LATCH];
  logic [21:0] latch_nxt [ssl_pkg::NUM_LATCH];

  // A load in the same cycle as a clock edge takes the old word, the host avoids it
  always_comb begin
    sr_nxt = sr_r;
    for (int i = 0; i < ssl_pkg::NUM_LATCH; i++) begin
      latch_nxt[i] = latch_r[i];
    end
    if (rise[5]) begin
      sr_nxt = {sr_r[20:0], sync_r[4]};
    end
    if (rise[3]) begin
      latch_nxt[sr_r[ssl_pkg::CTL_W-1:0]] = sr_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_r <= ssl_pkg::LATCH_RST;
      for (int i = 0; i < ssl_pkg::NUM_LATCH; i++) begin
        latch_r[i] <= ssl_pkg::LATCH_RST;
      end
    end else if (clk_en) begin
      sr_r <= sr_nxt;
      for (int i = 0; i < ssl_pkg::NUM_LATCH; i++) begin
        latch_r[i] <= latch_nxt[i];
      end
    end
  end

  // ==========================================================
  // Field decode
  logic [21:0] rf_ref_w;
  logic [21:0] if_ref_w;
  logic [21:0] rf_n_w;
  logic [21:0] if_n_w;
  logic        rf_run;
  logic        if_run;
  logic [7:0]  rf_p;
  logic [7:0]  if_p;
  logic [2:0]  mon_sel;

  function automatic logic [14:0] ref_count(input logic [21:0] w);
    ref_count = w[ssl_pkg::REF_LSB +: ssl_pkg::REF_W];
  endfunction

  function automatic logic [14:0] b_count(input logic [21:0] w);
    b_count = {2'b00, w[ssl_pkg::B_LSB +: ssl_pkg::B_W]};
  endfunction

  assign rf_ref_w = latch_r[ssl_pkg::DEST_RF_REF];
  assign if_ref_w = latch_r[ssl_pkg::DEST_IF_REF];
  assign rf_n_w   = latch_r[ssl_pkg::DEST_RF_N];
  assign if_n_w   = latch_r[ssl_pkg::DEST_IF_N];
  assign rf_run   = ~rf_ref_w[ssl_pkg::PWD_BIT];
  assign if_run   = ~if_ref_w[ssl_pkg::PWD_BIT];
  assign mon_sel  = rf_ref_w[ssl_pkg::MON_LSB +: ssl_pkg::MON_W];

  // Prescaler pair choice, band variant fixed at build time
  always_comb begin
    if (HIGH_BAND) begin
      rf_p = rf_ref_w[ssl_pkg::PSEL_BIT] ? ssl_pkg::RF_HB_P_HI : ssl_pkg::RF_HB_P_LO;
    end else begin
      rf_p = rf_ref_w[ssl_pkg::PSEL_BIT] ? ssl_pkg::RF_P_HI : ssl_pkg::RF_P_LO;
    end
    if_p = if_ref_w[ssl_pkg::PSEL_BIT] ? ssl_pkg::IF_P_HI : ssl_pkg::IF_P_LO;
  end

  // ==========================================================
  // Dividers; reference counters reuse the divider with P of one
  // Pins are sampled by clk, so input rates stay well under a quarter of it
  logic rf_n_term;
  logic if_n_term;
  logic rf_r_term;
  logic if_r_term;
  logic rf_mod;
  logic if_mod;

  ssl_dm_div u_rf_n (
    .clk     (clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .run     (rf_run),
    .step    (rise[2]),
    .p_val   (rf_p),
    .a_val   (rf_n_w[ssl_pkg::A_LSB +: ssl_pkg::A_W]),
    .b_val   (b_count(rf_n_w)),
    .mod_ctl (rf_mod),
    .term    (rf_n_term)
  );

  ssl_dm_div u_if_n (
    .clk     (clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .run     (if_run),
    .step    (rise[1]),
    .p_val   (if_p),
    .a_val   (if_n_w[ssl_pkg::A_LSB +: ssl_pkg::A_W]),
    .b_val   (b_count(if_n_w)),
    .mod_ctl (if_mod),
    .term    (if_n_term)
  );

  ssl_dm_div u_rf_r (
    .clk     (clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .run     (rf_run),
    .step    (rise[0]),
    .p_val   (ssl_pkg::REF_P),
    .a_val   (7'h00),
    .b_val   (ref_count(rf_ref_w)),
    .mod_ctl (),
    .term    (rf_r_term)
  );

  ssl_dm_div u_if_r (
    .clk     (clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .run     (if_run),
    .step    (rise[0]),
    .p_val   (ssl_pkg::REF_P),
    .a_val   (7'h00),
    .b_val   (ref_count(if_ref_w)),
    .mod_ctl (),
    .term    (if_r_term)
  );

  // ==========================================================
  // Lock detect: reference and counter pulses within the window
  logic [3:0] gap_r   [2];
  logic [3:0] gap_nxt [2];
  logic [1:0] lock_r;
  logic [1:0] lock_nxt;
  logic [1:0] ref_p;
  logic [1:0] n_p;
  logic [1:0] run_v;

  assign ref_p = {rf_r_term, if_r_term};
  assign n_p   = {rf_n_term, if_n_term};
  assign run_v = {rf_run, if_run};

  // Gap counts from the last unpaired pulse of either kind and saturates
  always_comb begin
    lock_nxt = lock_r;
    for (int c = 0; c < 2; c++) begin
      gap_nxt[c] = (gap_r[c] == 4'hF) ? gap_r[c] : gap_r[c] + 4'h1;
      if (!run_v[c]) begin
        lock_nxt[c] = 1'b0;
        gap_nxt[c]  = 4'hF;
      end else if (ref_p[c] && n_p[c]) begin
        lock_nxt[c] = 1'b1;
        gap_nxt[c]  = 4'hF;
      end else if (ref_p[c] || n_p[c]) begin
        if (gap_r[c] <= ssl_pkg::LOCK_WIN) begin
          lock_nxt[c] = 1'b1;
          gap_nxt[c]  = 4'hF;
        end else begin
          lock_nxt[c] = (gap_r[c] == 4'hF) ? lock_r[c] : 1'b0;
          gap_nxt[c]  = 4'h0;
        end
      end else if (gap_r[c] == ssl_pkg::LOCK_WIN + 4'h1) begin
        // Partner pulse missed the window
        lock_nxt[c] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r[0] <= 4'hF;
      gap_r[1] <= 4'hF;
      lock_r   <= 2'b00;
    end else if (clk_en) begin
      gap_r[0] <= gap_nxt[0];
      gap_r[1] <= gap_nxt[1];
      lock_r   <= lock_nxt;
    end
  end

  // ==========================================================
  // Monitor output and status pins, all registered
  logic mon_nxt;

  always_comb begin
    unique case (mon_sel)
      ssl_pkg::MON_LOW:    mon_nxt = 1'b0;
      ssl_pkg::MON_SR:     mon_nxt = sr_r[ssl_pkg::SR_W-1];
      ssl_pkg::MON_RF_N:   mon_nxt = rf_n_term;
      ssl_pkg::MON_IF_N:   mon_nxt = if_n_term;
      ssl_pkg::MON_RF_REF: mon_nxt = rf_r_term;
      ssl_pkg::MON_IF_REF: mon_nxt = if_r_term;
      ssl_pkg::MON_LOCK:   mon_nxt = &(lock_r | ~run_v) & |run_v;
      ssl_pkg::MON_HIGH:   mon_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      muxed_monitor_output <= 1'b0;
      rf_mod_ctl           <= 1'b0;
      if_mod_ctl           <= 1'b0;
      rf_power_down        <= 1'b0;
      if_power_down        <= 1'b0;
    end else if (clk_en) begin
      muxed_monitor_output <= mon_nxt;
      rf_mod_ctl           <= rf_mod;
      if_mod_ctl           <= if_mod;
      rf_power_down        <= ~rf_run;
      if_power_down        <= ~if_run;
    end
  end

endmodule

// [ssl_port_sva.sv]
// Checker for the serial load port outputs
`timescale 1ns/100ps
module ssl_port_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic rf_prescaler_input,
  input wire logic if_prescaler_input,
  input wire logic reference_counter_input,
  input wire logic muxed_monitor_output,
  input wire logic rf_mod_ctl,
  input wire logic if_mod_ctl,
  input wire logic rf_power_down,
  input wire logic if_power_down
);
  // ==========================================================
  // Cycles since a strobe rise or a prescaler edge, saturating
  logic [2:0] q_r, q_nxt;
  logic [3:0] ld_r, ld_nxt, rf_r, rf_nxt, if_r, if_nxt;
  always_comb begin
    q_nxt = {load_strobe, rf_prescaler_input, if_prescaler_input};
    ld_nxt = (load_strobe && !q_r[2]) ? 4'h0 : ld_r + {3'h0, ld_r != 4'hF};
    rf_nxt = (rf_prescaler_input && !q_r[1]) ? 4'h0 : rf_r + {3'h0, rf_r != 4'hF};
    if_nxt = (if_prescaler_input && !q_r[0]) ? 4'h0 : if_r + {3'h0, if_r != 4'hF};
  end
  // Frozen with the design so ages stay comparable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= 3'h0;
      ld_r <= 4'hF;
      rf_r <= 4'hF;
      if_r <= 4'hF;
    end else if (clk_en) begin
      q_r <= q_nxt;
      ld_r <= ld_nxt;
      rf_r <= rf_nxt;
      if_r <= if_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Output relations
  a_reset_outs_low: assert property ($rose(rst_n) |-> !(muxed_monitor_output || rf_mod_ctl
    || if_mod_ctl || rf_power_down || if_power_down)) else $error("outputs not low");
  a_freeze_holds: assert property (!clk_en |=> $stable({muxed_monitor_output,
    rf_mod_ctl, if_mod_ctl, rf_power_down, if_power_down})) else $error("freeze broken");
  a_rf_pd_load: assert property ($changed(rf_power_down) |-> ld_r <= 4'hC)
    else $error("rf power save moved without load");
  a_if_pd_load: assert property ($changed(if_power_down) |-> ld_r <= 4'hC)
    else $error("if power save moved without load");
  a_rf_pd_stop: assert property (rf_power_down [*4] |-> !rf_mod_ctl)
    else $error("rf swallow while powered down");
  a_if_pd_stop: assert property (if_power_down [*4] |-> !if_mod_ctl)
    else $error("if swallow while powered down");
  a_rf_mod_cause: assert property ($changed(rf_mod_ctl) |-> rf_r <= 4'hC || ld_r <= 4'hC)
    else $error("rf modulus moved without count");
  a_if_mod_cause: assert property ($changed(if_mod_ctl) |-> if_r <= 4'hC || ld_r <= 4'hC)
    else $error("if modulus moved without count");
endmodule
bind ssl_port ssl_port_sva u_ssl_port_sva (.*);

// [ssl_host.sv]
// Host model driving the serial programming pins
`timescale 1ns/100ps
module ssl_host (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      load_strobe
);
  // Serial clock stands low outside frames
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  // Data moves with the falling edge, four cycles either side of the rise: 80 ns period
  task automatic shift_bit(input logic b);
    ser_data <= b;
    repeat (4) @(posedge clk);
    ser_clk <= 1'b1;
    repeat (4) @(posedge clk);
    ser_clk <= 1'b0;
  endtask
  // Strobe only after the last bit; data line inverted before the strobe rises
  task automatic load();
    @(posedge clk);
    ser_data <= ~ser_data;
    repeat (4) @(posedge clk);
    load_strobe <= 1'b1;
    repeat (6) @(posedge clk);
    load_strobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic send(input logic [21:0] w);
    for (int i = 21; i >= 0; i--) shift_bit(w[i]);
    load();
  endtask
endmodule

// [ssl_port_tb_top.sv]
// Self-checking bench for the serial load port
`timescale 1ns/100ps
module ssl_port_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        rf_in = 1'b0, if_in = 1'b0, ref_in = 1'b0, fin_run = 1'b0;
  logic        seen_rf = 1'b0, seen_if = 1'b0, b;
  logic        ser_clk, ser_data, load_strobe, mon, rf_mod, if_mod, rf_pd, if_pd;
  logic [1:0]  ph = 2'h0;
  logic [21:0] lat [4] = '{default: 22'h000000};
  logic [21:0] sr_m = 22'h000000;
  logic [31:0] rnd;
  integer      seed = 32'h009549be;
  int          err_total = 0, samples_checked = 0, cyc = 0, pulses = 0;

  ssl_port #(.HIGH_BAND(1'b0)) u_ssl_port (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe),
    .rf_prescaler_input(rf_in), .if_prescaler_input(if_in),
    .reference_counter_input(ref_in), .muxed_monitor_output(mon), .rf_mod_ctl(rf_mod),
    .if_mod_ctl(if_mod), .rf_power_down(rf_pd), .if_power_down(if_pd));
  ssl_host u_ssl_host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_strobe(load_strobe));

  always #5 clk = ~clk;
  // Prescaler inputs at clk/8, well under the clk/4 limit; also the hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fin_run) ph <= ph + 2'h1;
    if (fin_run && ph == 2'h3) begin
      rf_in <= ~rf_in;
      if_in <= ~if_in;
      ref_in <= ~ref_in;
    end
    if (rf_mod === 1'b1) seen_rf <= 1'b1;
    if (if_mod === 1'b1) seen_if <= 1'b1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic s, input logic e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", nm, e, s);
    end
  endtask
  // Only selects 0, 1 and 7 are predictable at an arbitrary instant
  function automatic logic mon_exp();
    case (lat[ssl_pkg::DEST_RF_REF][ssl_pkg::MON_LSB +: ssl_pkg::MON_W])
      ssl_pkg::MON_SR:   return sr_m[ssl_pkg::SR_W-1];
      ssl_pkg::MON_HIGH: return 1'b1;
      default:           return 1'b0;
    endcase
  endfunction
  task automatic chk_outs();
    chk("rf_pd", rf_pd, lat[ssl_pkg::DEST_RF_REF][ssl_pkg::PWD_BIT]);
    chk("if_pd", if_pd, lat[ssl_pkg::DEST_IF_REF][ssl_pkg::PWD_BIT]);
    chk("mon", mon, mon_exp());
  endtask
  task automatic wr(input logic [1:0] code, input logic [19:0] pay);
    u_ssl_host.send({pay, code});
    sr_m = {pay, code};
    lat[code] = {pay, code};
    chk_outs();
  endtask
  task automatic summarize();
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_outs();
    // Every code thrice with random payload, monitor select kept low
    for (int i = 0; i < 12; i++) begin
      rnd = $random(seed);
      wr(i[1:0], {3'h0, rnd[16:0]});
    end
    // Shift register on the monitor; bits past 22 push the oldest out
    wr(ssl_pkg::DEST_RF_REF, 20'h20000);
    for (int i = 0; i < 30; i++) begin
      rnd = $random(seed);
      b = rnd[0];
      u_ssl_host.shift_bit(b);
      sr_m = {sr_m[20:0], b};
      repeat (2) @(posedge clk);
      chk("mon_sr", mon, sr_m[21]);
    end
    wr(ssl_pkg::DEST_RF_REF, 20'hE0000);
    wr(ssl_pkg::DEST_RF_REF, 20'h00004);
    // Both channels counting, a freeze, then power save
    wr(ssl_pkg::DEST_IF_REF, 20'h00004);
    wr(ssl_pkg::DEST_RF_N, 20'h00101);
    wr(ssl_pkg::DEST_IF_N, 20'h00101);
    fin_run <= 1'b1;
    repeat (1500) @(posedge clk);
    clk_en <= 1'b0;
    repeat (20) @(posedge clk);
    clk_en <= 1'b1;
    repeat (1500) @(posedge clk);
    chk("rf_mod_seen", seen_rf, 1'b1);
    chk("if_mod_seen", seen_if, 1'b1);
    // IF counter pulse on the monitor: ratio 2*8+1 rises, one rise per 8 clk, so 136 clk
    // A pulse can land at any instant, so the load bypasses the instant checks of wr
    u_ssl_host.send({20'h60004, ssl_pkg::DEST_RF_REF});
    lat[ssl_pkg::DEST_RF_REF] = {20'h60004, ssl_pkg::DEST_RF_REF};
    sr_m = lat[ssl_pkg::DEST_RF_REF];
    pulses = 0;
    repeat (1360) begin
      @(posedge clk);
      if (mon === 1'b1) pulses++;
    end
    chk("mon_if_n", pulses == 10, 1'b1);
    wr(ssl_pkg::DEST_RF_REF, 20'h10004);
    wr(ssl_pkg::DEST_IF_REF, 20'h10004);
    repeat (8) @(posedge clk);
    chk("rf_mod_off", rf_mod, 1'b0);
    chk("if_mod_off", if_mod, 1'b0);
    summarize();
  end
endmodule
